// ==== dpc_pkg.sv ====
package dpc_pkg;

    // register byte offsets
    localparam logic [7:0]  DPC_OFS_SRC_PTR   = 8'h00;
    localparam logic [7:0]  DPC_OFS_DST_PTR   = 8'h04;
    localparam logic [7:0]  DPC_OFS_SPACE     = 8'h08;
    localparam logic [7:0]  DPC_OFS_COUNT     = 8'h0C;
    localparam logic [7:0]  DPC_OFS_CTRL      = 8'h10;
    localparam logic [7:0]  DPC_OFS_STATUS    = 8'h14;

    // widths
    localparam int          DPC_AW            = 24;
    localparam int          DPC_CW            = 16;
    localparam int          DPC_FW            = 3;

    // space code register fields
    localparam int          DPC_SPC_DST_LSB   = 0;
    localparam int          DPC_SPC_SRC_LSB   = 4;

    // control register fields
    localparam int          DPC_CTL_START     = 0;
    localparam int          DPC_CTL_SRC_INC   = 1;
    localparam int          DPC_CTL_DST_INC   = 2;
    localparam int          DPC_CTL_SRC_OPERAND_SIZE_LSB = 4;
    localparam int          DPC_CTL_DST_OPERAND_SIZE_LSB = 6;

    // status register fields
    localparam int          DPC_STS_BUSY      = 0;
    localparam int          DPC_STS_DONE      = 1;

    // operand size codes
    localparam logic [1:0]  DPC_SIZE_BYTE     = 2'h1;
    localparam logic [1:0]  DPC_SIZE_WORD     = 2'h2;

    // reset values
    localparam logic [23:0] DPC_PTR_RST       = 24'h00_0000;
    localparam logic [15:0] DPC_CNT_RST       = 16'h0000;
    localparam logic [7:0]  DPC_SPC_RST       = 8'h00;
    localparam logic [1:0]  DPC_SIZE_RST      = 2'h1;
    localparam logic [31:0] DPC_RD_ZERO       = 32'h0000_0000;

    typedef struct packed {
        logic [1:0] dst_size;
        logic [1:0] src_size;
        logic       dst_inc_en;
        logic       src_inc_en;
    } dpc_ctrl_s;

    typedef struct packed {
        logic [DPC_AW-1:0] addr;
        logic [DPC_FW-1:0] space;
        logic              active;
    } dpc_bus_s;

endpackage : dpc_pkg

// ==== dpc_ptr_step.sv ====
`timescale 1ns/1ps
module dpc_ptr_step
    import dpc_pkg::*;
(
    // pointer and operand description
    input  wire logic [DPC_AW-1:0] ptr,
    input  wire logic [1:0]        size,
    input  wire logic              inc_en,
    input  wire logic              last_byte,
    // results
    output      logic [DPC_AW-1:0] ptr_next,
    output      logic [1:0]        bytes
);
    // word on even address moves two; byte, odd start or lone last byte moves one
    always_comb begin
        if (size == DPC_SIZE_WORD && !ptr[0] && !last_byte) begin
            bytes = 2'd2;
        end else begin
            bytes = 2'd1;
        end
        // 24-bit add wraps to zero past the top
        if (inc_en) begin
            ptr_next = ptr + DPC_AW'(bytes);
        end else begin
            ptr_next = ptr;
        end
    end

endmodule : dpc_ptr_step

// ==== dpc_top.sv ====
`timescale 1ns/1ps
// Behaviour
// R1: source pointer holds a 24-bit byte address; upper byte reserved.
// R2: read portion of an operand drives the address bus from source pointer.
// R3: source pointer advances or holds after each operand per its increment enable.
// R4: pointer additions wrap within 24 bits from all ones to zero.
// R5: source step is one or two from source size and address alignment.
// R6: destination pointer holds 24-bit address, drives bus during write portion.
// R7: destination pointer advances or holds after each operand per its enable.
// R8: destination step is one or two from destination size and address.
// R9: space code register gives 3-bit source and destination codes per cycle.
// R10: software initialises the space codes and never programs all ones.
// R11: 16-bit byte count sets length; zero means 65536 bytes.
// R12: count drops by one per byte moved; a word takes two.
// R13: channel stops at once when the byte count reaches zero.
// R14: odd counts work with word operands; last operand carries one byte, except from an odd destination address.
// R15: size code 01 is byte, 10 is word, others reserved.
// R16: end-of-transfer pin is driven as output when the count runs out.
// R17: reserved upper pointer bits ignore writes and read as zero.
module dpc_top
    import dpc_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output      logic [31:0]       reg_rdata,
    // channel sequencer
    input  wire logic              rd_cycle,
    input  wire logic              wr_cycle,
    input  wire logic              src_op_done,
    input  wire logic              dst_op_done,
    output      dpc_ctrl_s         chan_ctrl,
    output      logic              chan_run,
    output      logic              term_count,
    // master bus address and space
    output      dpc_bus_s          master_bus,
    // end-of-transfer pin
    input  wire logic              xfer_end_n_in,
    output      logic              xfer_end_n_out,
    output      logic              xfer_end_oe
);
    import dpc_pkg::*;

    logic              rst_sync1_q;
    logic              rst_sync2_q;
    logic              rst_n_int;

    logic [DPC_AW-1:0] src_ptr_q, src_ptr_d;
    logic [DPC_AW-1:0] dst_ptr_q, dst_ptr_d;
    logic [7:0]        space_q, space_d;
    logic [DPC_CW-1:0] count_q, count_d;
    logic              full_q, full_d;
    dpc_ctrl_s         ctrl_q, ctrl_d;
    logic              run_q, run_d;
    logic              done_q, done_d;
    logic [31:0]       rdata_q, rdata_d;
    dpc_bus_s          bus_q, bus_d;
    logic              tc_q, tc_d;
    logic              end_oe_q, end_oe_d;

    logic [DPC_AW-1:0] src_next, dst_next;
    logic [1:0]        src_bytes, dst_bytes;
    logic              last_byte;
    logic              count_zero;
    logic              last_op;
    logic [1:0]        src_size_eff, dst_size_eff;
    logic              wr_src, wr_dst, wr_spc, wr_cnt, wr_ctl, wr_sts;

    // reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_n_int = rst_sync2_q;

    // reserved size codes behave as byte
    assign src_size_eff = (ctrl_q.src_size == DPC_SIZE_WORD) ? DPC_SIZE_WORD
                                                              : DPC_SIZE_BYTE; // R15
    assign dst_size_eff = (ctrl_q.dst_size == DPC_SIZE_WORD) ? DPC_SIZE_WORD
                                                              : DPC_SIZE_BYTE; // R15

    assign count_zero = (count_q == DPC_CNT_RST) && !full_q;               // R11
    assign last_byte  = (count_q == DPC_CW'(1)) && !full_q;                // R14
    assign last_op    = last_byte || ((count_q == DPC_CW'(2)) && !full_q
                                      && dst_bytes == 2'd2);

    dpc_ptr_step u_src_step (
        .ptr       (src_ptr_q),
        .size      (src_size_eff),
        .inc_en    (ctrl_q.src_inc_en),
        .last_byte (last_byte),
        .ptr_next  (src_next),
        .bytes     (src_bytes)
    );

    dpc_ptr_step u_dst_step (
        .ptr       (dst_ptr_q),
        .size      (dst_size_eff),
        .inc_en    (ctrl_q.dst_inc_en),
        .last_byte (last_byte),
        .ptr_next  (dst_next),
        .bytes     (dst_bytes)
    );

    assign wr_src = reg_wr && reg_addr == DPC_OFS_SRC_PTR;
    assign wr_dst = reg_wr && reg_addr == DPC_OFS_DST_PTR;
    assign wr_spc = reg_wr && reg_addr == DPC_OFS_SPACE;
    assign wr_cnt = reg_wr && reg_addr == DPC_OFS_COUNT;
    assign wr_ctl = reg_wr && reg_addr == DPC_OFS_CTRL;
    assign wr_sts = reg_wr && reg_addr == DPC_OFS_STATUS;

    // register and channel state
    always_comb begin
        src_ptr_d = src_ptr_q;
        dst_ptr_d = dst_ptr_q;
        space_d   = space_q;
        count_d   = count_q;
        full_d    = full_q;
        ctrl_d    = ctrl_q;
        run_d     = run_q;
        done_d    = done_q;
        tc_d      = 1'b0;

        if (wr_src) begin
            src_ptr_d = reg_wdata[DPC_AW-1:0];                              // R1 R17
        end
        if (wr_dst) begin
            dst_ptr_d = reg_wdata[DPC_AW-1:0];                              // R6 R17
        end
        if (wr_spc) begin
            space_d = reg_wdata[7:0];                                       // R9
        end
        if (wr_cnt) begin
            count_d = reg_wdata[DPC_CW-1:0];                                // R11
            full_d  = 1'b0;
        end
        if (wr_ctl) begin
            ctrl_d.src_inc_en = reg_wdata[DPC_CTL_SRC_INC];                 // R3
            ctrl_d.dst_inc_en = reg_wdata[DPC_CTL_DST_INC];                 // R7
            ctrl_d.src_size   = reg_wdata[DPC_CTL_SRC_OPERAND_SIZE_LSB +: 2];
            ctrl_d.dst_size   = reg_wdata[DPC_CTL_DST_OPERAND_SIZE_LSB +: 2];
            if (reg_wdata[DPC_CTL_START] && !run_q) begin
                run_d  = 1'b1;
                full_d = (count_d == DPC_CNT_RST);                          // R11
            end else if (!reg_wdata[DPC_CTL_START]) begin
                run_d = 1'b0;
            end
        end
        if (wr_sts && reg_wdata[DPC_STS_DONE]) begin
            done_d = 1'b0;
        end

        if (run_q) begin
            if (src_op_done) begin
                src_ptr_d = src_next;                                       // R3 R4 R5
            end
            if (dst_op_done) begin
                dst_ptr_d = dst_next;                                       // R7 R4 R8
                count_d   = count_q - DPC_CW'(dst_bytes);                   // R12
                full_d    = 1'b0;
                if (last_op) begin
                    run_d  = 1'b0;                                          // R13
                    done_d = 1'b1;
                    tc_d   = 1'b1;
                end
            end
            if (!xfer_end_n_in && !end_oe_q) begin
                run_d  = 1'b0;
                done_d = 1'b1;
            end
            if (count_zero) begin
                run_d = 1'b0;                                               // R13
            end
        end
    end

    // master address and space code, registered
    always_comb begin
        bus_d        = '0;
        end_oe_d     = 1'b0;
        if (run_q && rd_cycle) begin
            bus_d.addr   = src_ptr_q;                                       // R2
            bus_d.space  = space_q[DPC_SPC_SRC_LSB +: DPC_FW];              // R9
            bus_d.active = 1'b1;
        end else if (run_q && wr_cycle) begin
            bus_d.addr   = dst_ptr_q;                                       // R6
            bus_d.space  = space_q[DPC_SPC_DST_LSB +: DPC_FW];              // R9
            bus_d.active = 1'b1;
            end_oe_d     = last_op;                                         // R16
        end
    end

    // read data, valid the cycle after the strobe
    always_comb begin
        rdata_d = DPC_RD_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                DPC_OFS_SRC_PTR: rdata_d = {8'h00, src_ptr_q};              // R17
                DPC_OFS_DST_PTR: rdata_d = {8'h00, dst_ptr_q};              // R17
                DPC_OFS_SPACE:   rdata_d = {24'h00_0000, space_q};
                DPC_OFS_COUNT:   rdata_d = {16'h0000, count_q};
                DPC_OFS_CTRL:    rdata_d = {24'h00_0000, ctrl_q.dst_size,
                                            ctrl_q.src_size, 1'b0,
                                            ctrl_q.dst_inc_en,
                                            ctrl_q.src_inc_en, run_q};
                DPC_OFS_STATUS:  rdata_d = {30'h0000_0000, done_q, run_q};
                default:         rdata_d = DPC_RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            src_ptr_q <= DPC_PTR_RST;
            dst_ptr_q <= DPC_PTR_RST;
            space_q   <= DPC_SPC_RST;
            count_q   <= DPC_CNT_RST;
            full_q    <= 1'b0;
            ctrl_q    <= '{dst_size: DPC_SIZE_RST, src_size: DPC_SIZE_RST,
                           dst_inc_en: 1'b0, src_inc_en: 1'b0};
            run_q     <= 1'b0;
            done_q    <= 1'b0;
            tc_q      <= 1'b0;
            bus_q     <= '0;
            end_oe_q  <= 1'b0;
            rdata_q   <= DPC_RD_ZERO;
        end else begin
            src_ptr_q <= src_ptr_d;
            dst_ptr_q <= dst_ptr_d;
            space_q   <= space_d;
            count_q   <= count_d;
            full_q    <= full_d;
            ctrl_q    <= ctrl_d;
            run_q     <= run_d;
            done_q    <= done_d;
            tc_q      <= tc_d;
            bus_q     <= bus_d;
            end_oe_q  <= end_oe_d;
            rdata_q   <= rdata_d;
        end
    end

    assign reg_rdata      = rdata_q;
    assign chan_ctrl      = ctrl_q;
    assign chan_run       = run_q;
    assign term_count     = tc_q;
    assign master_bus     = bus_q;
    assign xfer_end_oe    = end_oe_q;                                       // R16
    assign xfer_end_n_out = 1'b0;

endmodule : dpc_top

// ==== dpc_top_sva.sv ====
`timescale 1ns/1ps
module dpc_top_sva
    import dpc_pkg::*;
(
    // watched ports
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [7:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              rd_cycle,
    input wire logic              wr_cycle,
    input wire logic              src_op_done,
    input wire logic              dst_op_done,
    input wire dpc_pkg::dpc_ctrl_s chan_ctrl,
    input wire logic              chan_run,
    input wire logic              term_count,
    input wire dpc_pkg::dpc_bus_s master_bus,
    input wire logic              xfer_end_n_in,
    input wire logic              xfer_end_n_out,
    input wire logic              xfer_end_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_last_op;
        dst_op_done && xfer_end_oe;
    endsequence
    a_rd_drives_bus: assert property (chan_run && rd_cycle |=> master_bus.active)
        else $error("read portion left bus idle");
    a_wr_drives_bus: assert property (chan_run && wr_cycle |=> master_bus.active)
        else $error("write portion left bus idle");
    a_bus_idle_zero: assert property (!rd_cycle && !wr_cycle |=> master_bus == '0)
        else $error("bus not zero when idle");
    a_idle_refuses: assert property (!chan_run |=> !master_bus.active)
        else $error("bus active while stopped");
    a_last_halts: assert property (s_last_op |=> term_count && !chan_run)
        else $error("channel ran past zero count");
    a_term_pulse: assert property (term_count |=> !term_count)
        else $error("terminal count not one cycle");
    a_term_cause: assert property (term_count |-> $past(dst_op_done))
        else $error("terminal count without operand");
    a_end_drives_low: assert property (xfer_end_oe |-> !xfer_end_n_out)
        else $error("end pin driven high");
    a_end_in_write: assert property ($rose(xfer_end_oe) |-> $past(wr_cycle))
        else $error("end pin outside write");
    a_rdata_zero: assert property (!reg_rd |=> reg_rdata == '0)
        else $error("read data without read");
endmodule : dpc_top_sva

// ==== dpc_mem_model.sv ====
`timescale 1ns/1ps
module dpc_mem_model
    import dpc_pkg::*;
(
    // host bus side
    input  wire logic              clk,
    input  wire dpc_pkg::dpc_bus_s master_bus,
    // end-of-transfer pin and last bus address
    input  wire logic              end_req,
    input  wire logic              xfer_end_n_out,
    input  wire logic              xfer_end_oe,
    output      logic              xfer_end_n_in,
    output      logic [23:0]       last_addr
);
    // pulled-up pin, low while either party drives it
    assign xfer_end_n_in = !(end_req || (xfer_end_oe && !xfer_end_n_out));
    always @(posedge clk) begin
        if (master_bus.active) begin
            last_addr <= master_bus.addr;
        end
    end
endmodule : dpc_mem_model

// ==== dpc_top_test.sv ====
`timescale 1ns/1ps
module dpc_top_test;
    import dpc_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, rd_cycle, wr_cycle;
    logic        src_op_done, dst_op_done, chan_run, term_count, end_req;
    logic        xfer_end_n_in, xfer_end_n_out, xfer_end_oe;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [23:0] last_addr;
    dpc_ctrl_s   chan_ctrl;
    dpc_bus_s    master_bus;
    int          failures, samples_checked;

    dpc_top       dpc_top_inst (.*);
    dpc_mem_model dpc_mem_model_inst (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask : rd_chk

    // one operand: read portion, source done, write portion, destination done
    task automatic operand(input logic [23:0] sa, da, input logic [2:0] sc, dc,
                           input logic last);
        @(posedge clk);
        rd_cycle <= 1'b1;
        @(posedge clk);
        #1 chk("src bus", 32'({sa, sc, 1'b1}), 32'(master_bus));
        @(posedge clk);
        rd_cycle    <= 1'b0;
        src_op_done <= 1'b1;
        @(posedge clk);
        src_op_done <= 1'b0;
        wr_cycle    <= 1'b1;
        @(posedge clk);
        #1 chk("dst bus", 32'({da, dc, 1'b1}), 32'(master_bus));
        chk("end oe", 32'(last), 32'(xfer_end_oe));
        @(posedge clk);
        wr_cycle    <= 1'b0;
        dst_op_done <= 1'b1;
        @(posedge clk);
        dst_op_done <= 1'b0;
        #1 chk("term", 32'(last), 32'(term_count));
        chk("model addr", 32'(da), 32'(last_addr));
    endtask : operand

    task automatic test_regs;
        rd_chk(DPC_OFS_SRC_PTR, 32'h0000_0000, "src rst");
        wr(DPC_OFS_SRC_PTR, 32'hAB12_3456);
        rd_chk(DPC_OFS_SRC_PTR, 32'h0012_3456, "src ptr");
        wr(DPC_OFS_DST_PTR, 32'hFFFF_FFFF);
        rd_chk(DPC_OFS_DST_PTR, 32'h00FF_FFFF, "dst ptr");
        wr(DPC_OFS_COUNT, 32'h0001_2345);
        rd_chk(DPC_OFS_COUNT, 32'h0000_2345, "count");
        rd_chk(8'h20, DPC_RD_ZERO, "unmapped");
        $display("test regs done");
    endtask : test_regs

    task automatic test_wrap;
        wr(DPC_OFS_SPACE, 32'h0000_0052);
        rd_chk(DPC_OFS_SPACE, 32'h0000_0052, "space");
        wr(DPC_OFS_SRC_PTR, 32'h00FF_FFFE);
        wr(DPC_OFS_DST_PTR, 32'h0000_0100);
        wr(DPC_OFS_COUNT, 32'h0000_0003);
        wr(DPC_OFS_CTRL, 32'h0000_00A7);
        #1 chk("ctrl", 32'h0000_002B, 32'(chan_ctrl));
        operand(24'hFF_FFFE, 24'h00_0100, 3'h5, 3'h2, 1'b0);
        operand(24'h00_0000, 24'h00_0102, 3'h5, 3'h2, 1'b1);
        chk("run", 32'h0, 32'(chan_run));
        rd_chk(DPC_OFS_SRC_PTR, 32'h0000_0001, "src end");
        rd_chk(DPC_OFS_DST_PTR, 32'h0000_0103, "dst end");
        rd_chk(DPC_OFS_COUNT, 32'h0000_0000, "count end");
        rd_chk(DPC_OFS_STATUS, 32'h0000_0002, "status");
        wr(DPC_OFS_STATUS, 32'h0000_0002);
        rd_chk(DPC_OFS_STATUS, 32'h0000_0000, "status clr");
        $display("test wrap done");
    endtask : test_wrap

    task automatic test_hold;
        wr(DPC_OFS_SPACE, 32'h0000_0034);
        wr(DPC_OFS_SRC_PTR, 32'h0000_0011);
        wr(DPC_OFS_DST_PTR, 32'h0000_0021);
        wr(DPC_OFS_COUNT, 32'h0000_0000);
        wr(DPC_OFS_CTRL, 32'h0000_00A5);
        operand(24'h00_0011, 24'h00_0021, 3'h3, 3'h4, 1'b0);
        operand(24'h00_0011, 24'h00_0022, 3'h3, 3'h4, 1'b0);
        rd_chk(DPC_OFS_SRC_PTR, 32'h0000_0011, "src held");
        rd_chk(DPC_OFS_DST_PTR, 32'h0000_0024, "dst step");
        rd_chk(DPC_OFS_COUNT, 32'h0000_FFFD, "count full");
        @(posedge clk);
        end_req <= 1'b1;
        repeat (3) @(posedge clk);
        end_req <= 1'b0;
        #1 chk("ext end run", 32'h0, 32'(chan_run));
        // source increment on, channel stopped: idle pulses must not step
        wr(DPC_OFS_CTRL, 32'h0000_00A2);
        @(posedge clk);
        src_op_done <= 1'b1;
        rd_cycle    <= 1'b1;
        @(posedge clk);
        src_op_done <= 1'b0;
        rd_cycle    <= 1'b0;
        rd_chk(DPC_OFS_SRC_PTR, 32'h0000_0011, "idle src");
        $display("test hold done");
    endtask : test_hold

    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        failures = 0;
        samples_checked = 0;
        {rst_n, reg_wr, reg_rd, rd_cycle, wr_cycle, src_op_done, dst_op_done} = '0;
        {reg_addr, reg_wdata, end_req} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        test_regs;
        test_wrap;
        test_hold;
        print_verdict;
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        print_verdict;
    end
endmodule : dpc_top_test

bind dpc_top dpc_top_sva dpc_top_sva_inst (.*);
